/* File: pkg/cmcrc_pkg.sv */
// constants, types and crc functions of the configuration memory crc checker
//
// Behaviour
// - each configuration frame carries a 16-bit crc
// - frame crc mismatch drives config status low
// - one 32-bit crc covers whole memory
// - compare-result and expected-value registers, 32 bits
// - non-zero compare result drives error high
// - compare result zero when memory intact
// - expected value loaded at configuration end
// - expected value transferred into compare circuit
// - scan instruction makes expected value scan chain
// - scanning does not halt checking
// - checking starts automatically in user mode
// - error low until a pass finds corruption
// - error holds through next pass, no history
// - clean pass drives error low again
// - passes repeat until device reset or end of user mode
// - check clock from divided oscillator, 80MHz..312.5kHz
// - divisor is two to the n, n 0..8
// - 10-bit instruction code selects 32-bit chain
package cmcrc_pkg;

    // ----------------------------------------------------------------
    // clocking
    // ----------------------------------------------------------------
    localparam int unsigned REF_FREQ_KHZ = 200000;
    localparam int unsigned OSC_FREQ_KHZ = 80000;
    localparam int unsigned CHECK_MAX_FREQ_KHZ = 80000;
    localparam int unsigned CHECK_MIN_FREQ_HZ = 312500;
    localparam logic [3:0] DIV_EXP_MAX = 4'h8;
    localparam logic [3:0] DIV_EXP_RESET = 4'h0;

    // ----------------------------------------------------------------
    // scan access
    // ----------------------------------------------------------------
    localparam logic [9:0] EXPECTED_VALUE_SCAN_INSTR = 10'h015;
    localparam int unsigned SCAN_CHAIN_LEN = 32;

    // ----------------------------------------------------------------
    // crc definitions and reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC32_INIT = 32'hffffffff;
    localparam logic [15:0] CRC16_POLY = 16'h8005;
    localparam logic [15:0] CRC16_INIT = 16'hffff;
    localparam logic [31:0] EXPECTED_RESET = 32'h00000000;
    localparam logic [31:0] COMPARE_RESET = 32'h00000000;

    typedef enum logic [1:0] {
        CMCRC_IDLE = 2'b00,
        CMCRC_LOAD = 2'b01,
        CMCRC_SCAN = 2'b11,
        CMCRC_DONE = 2'b10
    } cmcrc_state_type;

    // ----------------------------------------------------------------
    // crc over one 32-bit word, msb first
    // ----------------------------------------------------------------
    function automatic logic [31:0] cmcrc_crc32_word(input logic [31:0] crc,
                                                     input logic [31:0] data);
        logic [31:0] c;
        logic fb;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            fb = c[31] ^ data[i];
            c = {c[30:0], 1'b0} ^ (fb ? CRC32_POLY : 32'h00000000);
        end
        return c;
    endfunction

    function automatic logic [15:0] cmcrc_crc16_word(input logic [15:0] crc,
                                                     input logic [31:0] data);
        logic [15:0] c;
        logic fb;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            fb = c[15] ^ data[i];
            c = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
        end
        return c;
    endfunction

endpackage

/* File: rtl/cmcrc_checker.sv */
// configuration memory crc checker: frame crc, background crc, scan access
`timescale 1ns/10ps
module cmcrc_checker #(
    parameter int unsigned MEM_WORDS = 64,
    parameter int unsigned ADDR_W = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_crc_enable,
    input wire logic [3:0] i_div_exp,
    input wire logic i_cfg_wr,
    input wire logic [31:0] i_cfg_data,
    input wire logic i_cfg_frame_end,
    input wire logic [15:0] i_cfg_frame_crc,
    input wire logic i_cfg_done,
    input wire logic [31:0] i_cfg_signature,
    input wire logic i_user_mode,
    input wire logic i_upset_wr,
    input wire logic [ADDR_W-1:0] i_upset_addr,
    input wire logic [31:0] i_upset_mask,
    input wire logic i_jtag_tck,
    input wire logic i_jtag_tdi,
    input wire logic i_jtag_shift_dr,
    input wire logic [9:0] i_jtag_ir,
    output logic o_jtag_tdo,
    output logic o_crc_error,
    output logic [31:0] o_crc_compare_result,
    output logic o_pass_done,
    output logic o_checking,
    output logic o_config_status_low_n
);
    import cmcrc_pkg::*;

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(MEM_WORDS - 1);

    // ----------------------------------------------------------------
    // configuration memory
    // ----------------------------------------------------------------
    // no reset on the cells: they only carry meaning after loading
    logic [31:0] config_memory_cells [MEM_WORDS];
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_word;

    assign rd_word = config_memory_cells[rd_addr];

    always_ff @(posedge i_ref_clk) begin
        if (i_cfg_wr && !i_user_mode) begin
            config_memory_cells[wr_addr] <= i_cfg_data;
        end else if (i_upset_wr) begin
            // upsets flip stored bits while the design runs
            config_memory_cells[i_upset_addr] <= config_memory_cells[i_upset_addr]
                ^ i_upset_mask;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            wr_addr <= '0;
        end else if (i_cfg_wr && !i_user_mode) begin
            wr_addr <= (wr_addr == LAST_ADDR) ? '0 : wr_addr + ADDR_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // per-frame crc during configuration
    // ----------------------------------------------------------------
    logic [15:0] frame_crc;
    logic [15:0] next_frame_crc;

    always_comb begin
        next_frame_crc = frame_crc;
        if (i_cfg_wr && !i_user_mode) begin
            next_frame_crc = cmcrc_crc16_word(frame_crc, i_cfg_data);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            frame_crc <= CRC16_INIT;
        end else if (i_cfg_frame_end) begin
            frame_crc <= CRC16_INIT;
        end else begin
            frame_crc <= next_frame_crc;
        end
    end

    // a failed frame keeps status low until reset restarts configuration
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_config_status_low_n <= 1'b1;
        end else if (i_cfg_frame_end && !i_user_mode
                     && (next_frame_crc != i_cfg_frame_crc)) begin
            o_config_status_low_n <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // scan pin synchronisers
    // ----------------------------------------------------------------
    logic [12:0] jtag_meta;
    logic [12:0] jtag_sync;
    logic tck_prev;
    logic tck_rise;
    logic scan_selected;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            jtag_meta <= 13'h0000;
            jtag_sync <= 13'h0000;
            tck_prev <= 1'b0;
        end else begin
            jtag_meta <= {i_jtag_ir, i_jtag_shift_dr, i_jtag_tdi, i_jtag_tck};
            jtag_sync <= jtag_meta;
            tck_prev <= jtag_sync[0];
        end
    end

    assign tck_rise = jtag_sync[0] && !tck_prev;
    assign scan_selected = (jtag_sync[12:3] == EXPECTED_VALUE_SCAN_INSTR)
        && jtag_sync[2] && i_user_mode;

    // ----------------------------------------------------------------
    // expected value register
    // ----------------------------------------------------------------
    logic [31:0] crc_expected_value;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            crc_expected_value <= EXPECTED_RESET;
        end else if (i_cfg_done && !i_user_mode) begin
            crc_expected_value <= i_cfg_signature;
        end else if (scan_selected && tck_rise) begin
            // shifts in place; the checker samples it only at pass start
            crc_expected_value <= {jtag_sync[1], crc_expected_value[31:1]};
        end
    end

    // tdo lags the chain by one reference cycle, far below a tck period
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_jtag_tdo <= 1'b0;
        end else begin
            o_jtag_tdo <= crc_expected_value[0];
        end
    end

    // ----------------------------------------------------------------
    // check rate
    // ----------------------------------------------------------------
    logic [3:0] div_exp;
    logic check_tick;

    cmcrc_clk_div u_clk_div (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_div_exp(div_exp),
        .o_check_tick(check_tick)
    );

    // ----------------------------------------------------------------
    // background check sequencer
    // ----------------------------------------------------------------
    cmcrc_state_type state;
    logic [31:0] run_crc;
    logic [31:0] snap_expected;
    logic run_allowed;

    assign run_allowed = i_user_mode && i_crc_enable;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state <= CMCRC_IDLE;
        end else if (!run_allowed) begin
            state <= CMCRC_IDLE;
        end else if (check_tick) begin
            unique case (state)
                CMCRC_IDLE: begin
                    state <= CMCRC_LOAD;
                end
                CMCRC_LOAD: begin
                    state <= CMCRC_SCAN;
                end
                CMCRC_SCAN: begin
                    if (rd_addr == LAST_ADDR) begin
                        state <= CMCRC_DONE;
                    end
                end
                CMCRC_DONE: begin
                    state <= CMCRC_LOAD;
                end
            endcase
        end
    end

    // divisor is taken only while idle, before the first pass, so a run of passes never mixes rates
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            div_exp <= DIV_EXP_RESET;
        end else if (state == CMCRC_IDLE) begin
            div_exp <= (i_div_exp > DIV_EXP_MAX) ? DIV_EXP_MAX : i_div_exp;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            rd_addr <= '0;
        end else if (check_tick && state == CMCRC_SCAN) begin
            rd_addr <= (rd_addr == LAST_ADDR) ? '0 : rd_addr + ADDR_W'(1);
        end else if (state != CMCRC_SCAN) begin
            rd_addr <= '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            run_crc <= CRC32_INIT;
            snap_expected <= EXPECTED_RESET;
        end else if (check_tick && run_allowed) begin
            if (state == CMCRC_LOAD) begin
                run_crc <= CRC32_INIT;
                snap_expected <= crc_expected_value;
            end else if (state == CMCRC_SCAN) begin
                run_crc <= cmcrc_crc32_word(run_crc, rd_word);
            end
        end
    end

    // ----------------------------------------------------------------
    // result and error pin
    // ----------------------------------------------------------------
    logic pass_end;
    logic [31:0] next_compare;

    assign pass_end = check_tick && run_allowed && (state == CMCRC_DONE);
    assign next_compare = run_crc ^ snap_expected;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_crc_compare_result <= COMPARE_RESET;
        end else if (pass_end) begin
            o_crc_compare_result <= next_compare;
        end
    end

    // reflects only the last finished pass; leaving user mode clears it
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_crc_error <= 1'b0;
        end else if (!run_allowed) begin
            o_crc_error <= 1'b0;
        end else if (pass_end) begin
            o_crc_error <= |next_compare;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_pass_done <= 1'b0;
            o_checking <= 1'b0;
        end else begin
            o_pass_done <= pass_end;
            o_checking <= run_allowed && (state != CMCRC_IDLE);
        end
    end

endmodule

/* File: rtl/cmcrc_clk_div.sv */
// check-rate enable: oscillator emulation divided by two to the n
`timescale 1ns/10ps
module cmcrc_clk_div (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_div_exp,
    output logic o_check_tick
);
    import cmcrc_pkg::*;

    // ----------------------------------------------------------------
    // oscillator rate as a fractional accumulator
    // ----------------------------------------------------------------
    // averages exactly to the oscillator rate; jitter of one reference
    // cycle is harmless since the check logic only counts ticks
    localparam logic [17:0] ACC_STEP = 18'(OSC_FREQ_KHZ);
    localparam logic [17:0] ACC_WRAP = 18'(REF_FREQ_KHZ);

    logic [17:0] acc;
    logic [18:0] acc_sum;
    logic osc_tick;
    logic [7:0] div_cnt;
    logic [7:0] div_mask;

    assign acc_sum = {1'b0, acc} + {1'b0, ACC_STEP};
    assign osc_tick = (acc_sum >= {1'b0, ACC_WRAP});
    assign div_mask = 8'((9'h001 << i_div_exp) - 9'h001);

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            acc <= 18'h00000;
        end else if (osc_tick) begin
            acc <= 18'(acc_sum - {1'b0, ACC_WRAP});
        end else begin
            acc <= acc_sum[17:0];
        end
    end

    // ----------------------------------------------------------------
    // power-of-two divider
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            div_cnt <= 8'h00;
        end else if (osc_tick) begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_check_tick <= 1'b0;
        end else begin
            o_check_tick <= osc_tick && ((div_cnt & div_mask) == div_mask);
        end
    end

endmodule

/* File: testbench/cmcrc_checker_tb.sv */
// self-checking bench of the configuration memory crc checker
`timescale 1ns/10ps
module cmcrc_checker_tb;
    import cmcrc_pkg::*;
    localparam int NW = 4;
    typedef struct packed {logic [1:0] a; logic [31:0] m; logic e;} cmcrc_row_type;
    cmcrc_row_type rows [5] = '{'{2'h0, 32'h0, 1'b0}, '{2'h2, 32'h1, 1'b1},
        '{2'h2, 32'h1, 1'b0}, '{2'h3, 32'h80000000, 1'b1}, '{2'h3, 32'h80000000, 1'b0}};
    logic [31:0] mem [NW] = '{32'h9e3779b9, 32'h0000ffff, 32'h80000001, 32'h5a5ac3c3};
    logic [3:0] dv [3] = '{4'h0, 4'h3, 4'h9};
    logic clk, nrst, en, cwr, fend, cdone, umode, uwr, tck, tdi, sdr, tdo, err, pdone;
    logic busy, stn;
    logic [3:0] dexp;
    logic [31:0] cdata, csig, umask, cmp, sig, bad, got, f;
    logic [15:0] fcrc;
    logic [1:0] uaddr;
    logic [9:0] ir;
    int errors = 0;
    int n_tests = 0;
    int k;
    cmcrc_checker #(.MEM_WORDS(NW), .ADDR_W(2)) u_cmcrc_checker (
        .i_ref_clk(clk), .i_nrst(nrst), .i_crc_enable(en), .i_div_exp(dexp),
        .i_cfg_wr(cwr), .i_cfg_data(cdata), .i_cfg_frame_end(fend), .i_cfg_frame_crc(fcrc),
        .i_cfg_done(cdone), .i_cfg_signature(csig), .i_user_mode(umode), .i_upset_wr(uwr),
        .i_upset_addr(uaddr), .i_upset_mask(umask), .i_jtag_tck(tck), .i_jtag_tdi(tdi),
        .i_jtag_shift_dr(sdr), .i_jtag_ir(ir), .o_jtag_tdo(tdo), .o_crc_error(err),
        .o_crc_compare_result(cmp), .o_pass_done(pdone), .o_checking(busy),
        .o_config_status_low_n(stn));
    cmcrc_jtag_model u_cmcrc_jtag_model (.i_ref_clk(clk), .i_jtag_tdo(tdo), .o_tck(tck),
        .o_tdi(tdi), .o_shift_dr(sdr), .o_ir(ir));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] crcw(input logic [31:0] c, input logic [31:0] d,
                                         input logic [31:0] p, input int w);
        for (int i = 31; i >= 0; i--) begin
            c = ((c << 1) ^ ((c[w-1] ^ d[i]) ? p : 32'h0)) & (w == 32 ? 32'hffffffff : 32'hffff);
        end
        return c;
    endfunction
    function automatic logic [31:0] memcrc();
        logic [31:0] c;
        c = 32'hffffffff;
        foreach (mem[i]) c = crcw(c, mem[i], 32'h04c11db7, 32);
        return c;
    endfunction
    task automatic give_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // k returns the cycles spent waiting for all n pulses
    task automatic wait_pass(input int n, output int k);
        k = 0;
        while (n > 0) begin
            @(posedge clk);
            k++;
            if (pdone === 1'b1) n--;
            if (k > 20000) begin
                errors++;
                give_verdict();
            end
        end
    endtask
    initial begin
        {nrst, cwr, fend, cdone, umode, uwr, dexp, uaddr} <= '0;
        {cdata, csig, umask, fcrc} <= '0;
        en <= 1'b1;
        repeat (12) @(posedge clk);
        chk("reset_flags", 32'({err, busy, stn, tdo}), 32'h2);
        chk("reset_compare", cmp, 32'h0);
        nrst <= 1'b1;
        sig = memcrc();
        f = 32'hffff;
        for (int i = 0; i < NW; i++) begin
            f = crcw(f, mem[i], 32'h8005, 16);
            @(posedge clk);
            cwr <= 1'b1;
            cdata <= mem[i];
            fend <= i[0];
            fcrc <= f[15:0];
            if (i[0]) f = 32'hffff;
        end
        @(posedge clk);
        {cwr, fend} <= '0;
        cdone <= 1'b1;
        csig <= sig;
        @(posedge clk);
        cdone <= 1'b0;
        umode <= 1'b1;
        chk("status_n", 32'(stn), 32'h1);
        foreach (rows[r]) begin
            @(posedge clk);
            uwr <= 1'b1;
            uaddr <= rows[r].a;
            umask <= rows[r].m;
            @(posedge clk);
            uwr <= 1'b0;
            mem[rows[r].a] ^= rows[r].m;
            wait_pass(2, k);
            chk("crc_error", 32'(err), 32'(rows[r].e));
            chk("compare", cmp, memcrc() ^ sig);
        end
        bad = sig ^ 32'h10;
        u_cmcrc_jtag_model.shift(bad, got);
        chk("scan_out", got, sig);
        chk("checking", 32'(busy), 32'h1);
        wait_pass(2, k);
        chk("crc_error", 32'(err), 32'h1);
        chk("compare", cmp, 32'h10);
        umode <= 1'b0;
        repeat (4) @(posedge clk);
        chk("idle_flags", 32'({err, busy}), 32'h0);
        foreach (dv[j]) begin
            dexp <= dv[j];
            @(posedge clk);
            umode <= 1'b1;
            wait_pass(2, k);
            wait_pass(1, k);
            chk("pass_cycles", 32'(k), 32'((NW + 2) * 5 * (1 << (dv[j] > 8 ? 8 : dv[j])) / 2));
            umode <= 1'b0;
            repeat (4) @(posedge clk);
        end
        // feature switched off in user mode, then on; the scanned bad value still stands
        en <= 1'b0;
        umode <= 1'b1;
        repeat (700) @(posedge clk);
        chk("disabled", 32'({err, busy}), 32'h0);
        en <= 1'b1;
        wait_pass(1, k);
        chk("enabled", 32'({err, busy}), 32'h3);
        // reset in mid-run stops the passes and clears every result
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("mid_reset", 32'({err, busy, pdone, stn, tdo}), 32'h2);
        chk("mid_reset_compare", cmp, 32'h0);
        nrst <= 1'b1;
        umode <= 1'b0;
        repeat (4) @(posedge clk);
        cwr <= 1'b1;
        fend <= 1'b1;
        cdata <= 32'h0;
        fcrc <= 16'(~crcw(32'hffff, 32'h0, 32'h8005, 16));
        @(posedge clk);
        {cwr, fend} <= '0;
        repeat (2) @(posedge clk);
        chk("status_n", 32'(stn), 32'h0);
        give_verdict();
    end
endmodule

/* File: testbench/cmcrc_jtag_model.sv */
// jtag tester model that shifts the expected value scan chain
`timescale 1ns/10ps
module cmcrc_jtag_model (
    input wire logic i_ref_clk,
    input wire logic i_jtag_tdo,
    output logic o_tck,
    output logic o_tdi,
    output logic o_shift_dr,
    output logic [9:0] o_ir
);
    import cmcrc_pkg::*;
    initial begin
        o_tck = 1'b0;
        o_tdi = 1'b0;
        o_shift_dr = 1'b0;
        o_ir = 10'h3ff;
    end
    // lsb leaves first; slow tck so the pin synchronisers see every phase
    task automatic shift(input logic [31:0] v, output logic [31:0] got);
        @(posedge i_ref_clk);
        o_ir <= EXPECTED_VALUE_SCAN_INSTR;
        o_shift_dr <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            o_tdi <= v[i];
            repeat (6) @(posedge i_ref_clk);
            got[i] = i_jtag_tdo;
            o_tck <= 1'b1;
            repeat (6) @(posedge i_ref_clk);
            o_tck <= 1'b0;
        end
        o_shift_dr <= 1'b0;
        o_ir <= 10'h3ff;
        o_tdi <= ~v[31];
    endtask
endmodule

/* File: testbench/cmcrc_props_checker.sv */
// concurrent checks on the ports of the configuration memory crc checker
`timescale 1ns/10ps
module cmcrc_props #(
    parameter int unsigned MEM_WORDS = 64
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_crc_enable,
    input wire logic i_user_mode,
    input wire logic i_cfg_frame_end,
    input wire logic o_crc_error,
    input wire logic [31:0] o_crc_compare_result,
    input wire logic o_pass_done,
    input wire logic o_checking,
    input wire logic o_config_status_low_n
);
    logic run;
    assign run = i_user_mode && i_crc_enable;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_end;
        o_pass_done;
    endsequence
    // a pass needs far more than eight cycles even at the fastest tick
    sequence s_quiet;
        !o_pass_done [*8];
    endsequence
    err_from_result_a:
        assert property (s_end |-> o_crc_error == (|o_crc_compare_result))
        else $error("error pin disagrees with compare result");
    err_at_pass_a:
        assert property ($changed(o_crc_error) && o_checking |-> ##[0:1] s_end)
        else $error("error pin moved away from a pass end");
    result_at_pass_a:
        assert property ($changed(o_crc_compare_result) && o_checking |-> ##[0:1] s_end)
        else $error("compare result moved away from a pass end");
    idle_clear_a:
        assert property (!run [*3] |-> !o_crc_error && !o_checking)
        else $error("checker active or error high outside user mode");
    // the first tick may lie a whole divider period away at the slowest rate
    auto_start_a:
        assert property ($rose(run) |-> ##[1:700] o_checking)
        else $error("checking did not start in user mode");
    keep_running_a:
        assert property (o_checking && run ##1 run |-> o_checking)
        else $error("checking stopped while enabled");
    pass_pulse_a:
        assert property (s_end |=> s_quiet)
        else $error("pass done pulse too long or too close");
    status_cause_a:
        assert property ($fell(o_config_status_low_n) |-> $past(i_cfg_frame_end) && !$past(i_user_mode))
        else $error("status low without a frame end");
    status_sticky_a:
        assert property (!o_config_status_low_n |=> !o_config_status_low_n)
        else $error("status low released before reset");
endmodule
bind cmcrc_checker cmcrc_props #(.MEM_WORDS(MEM_WORDS)) u_cmcrc_props (
    .i_ref_clk, .i_nrst, .i_crc_enable, .i_user_mode, .i_cfg_frame_end, .o_crc_error,
    .o_crc_compare_result, .o_pass_done, .o_checking, .o_config_status_low_n);
